//--- hdl/uim_pkg.sv
/*
 * Package for the UART host register bank: register indices, field
 * positions, reset values, commands and the receive entry layout.
 * Assumes a 32-bit AHB-Lite host; byte address is four times the index.
 */
package uim_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [7:0] IDX_QUEUE    = 8'h03;
  localparam logic [7:0] IDX_RX_FILL  = 8'h10;
  localparam logic [7:0] IDX_TX_EMPTY = 8'h11;
  localparam logic [7:0] IDX_STATUS   = 8'h21;
  localparam logic [7:0] IDX_COMMAND  = 8'h22;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h24;
  localparam logic [7:0] IDX_MASK     = 8'h25;
  localparam logic [7:0] IDX_CONTROL  = 8'h26;
  localparam logic [7:0] IDX_RESUME   = 8'h41;
  localparam logic [7:0] IDX_PAUSE    = 8'h42;
  localparam logic [7:0] IDX_WAKE     = 8'h43;
  localparam logic [7:0] IDX_FLOW     = 8'h44;
  localparam logic [7:0] IDX_RX_THR   = 8'h46;
  localparam logic [7:0] IDX_TX_THR   = 8'h47;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] RST_RESUME  = 8'h11;
  localparam logic [7:0] RST_PAUSE   = 8'h13;
  localparam logic [7:0] RST_WAKE    = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'h00;
  localparam logic [7:0] RST_THR     = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h03;
  localparam logic [7:0] CMD_RST_ERR = 8'h04;
  localparam logic [6:0] WDOG_BITS   = 7'h40;
  localparam logic [8:0] DEPTH       = 9'h100;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int M_COS = 7, M_WDOG = 6, M_ADDR = 5, M_FLOW = 4;
  localparam int M_CT = 3, M_BRK = 2, M_RX = 1, M_TX = 0;
  localparam int C_LEN = 0, C_BLOCK = 2, C_FLOW_EN = 3, C_ADDR_EN = 4;
  localparam int S_RECEIVER_READY_FLAG = 0, S_RXFULL = 1, S_TRANSMITTER_READY_FLAG = 2, S_TXEMPTY = 3;
  localparam int S_ERR = 4;
  localparam int F_TX_RESUME = 4, F_TX_PAUSE = 5;
  localparam int F_RX_PAUSE = 6, F_RX_RESUME = 7;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } uim_rx_entry_t;

  // Character length code 0..3 means 5..8 bits
  function automatic logic [7:0] char_mask(input logic [1:0] len);
    case (len)
      2'h0:    char_mask = 8'h1f;
      2'h1:    char_mask = 8'h3f;
      2'h2:    char_mask = 8'h7f;
      default: char_mask = 8'hff;
    endcase
  endfunction : char_mask

endpackage : uim_pkg

//--- hdl/uim_regs.sv
/*
 * Host register bank of a single-channel UART: interrupt mask, receive
 * and transmit queues, thresholds, level counters, compare characters
 * and flow-character status.
 * Assumes: serial engines on the same clock; one AHB-Lite master.
 */
`timescale 1ns/10ps

module uim_regs (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  input  wire logic                   rx_push_valid,
  input  wire uim_pkg::uim_rx_entry_t rx_push_entry,
  output logic                        rx_space,
  input  wire logic                   tx_take,
  output logic                        tx_valid,
  output logic [7:0]                  tx_data,
  input  wire logic                   idle_bit_tick,
  input  wire logic                   port_change_detect,
  input  wire logic                   counter_zero,
  input  wire logic                   break_change,
  input  wire logic                   tx_resume_sent,
  input  wire logic                   tx_pause_sent,
  input  wire logic [3:0]             tx_flow_state,
  output logic                        resume_match,
  output logic                        pause_match,
  output logic                        wake_match,
  output logic                        interrupt_request_out_n
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic       acc, rd_acc, addr_ok;
  logic [7:0] idx;
  logic       wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [7:0] wdat;
  logic       wr;

  assign idx     = haddr[9:2];
  assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  assign acc     = hsel && hready && (htrans == uim_pkg::HTRANS_NSEQ) && addr_ok;
  assign rd_acc  = acc && !hwrite;
  assign wdat    = hwdata[7:0];
  assign wr      = wr_pend_q;

  // Writes land in the data phase, when hwdata stands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= acc && hwrite;
      wr_idx_q  <= idx;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] mask_q, ctl_q, resume_q, pause_q, wake_q, rx_thr_q, tx_thr_q;
  logic       rx_ovr_q, tx_ovr_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q   <= uim_pkg::RST_MASK;
      ctl_q    <= uim_pkg::RST_CONTROL;
      resume_q <= uim_pkg::RST_RESUME;
      pause_q  <= uim_pkg::RST_PAUSE;
      wake_q   <= uim_pkg::RST_WAKE;
    end else if (wr) begin
      case (wr_idx_q)
        uim_pkg::IDX_MASK:    mask_q   <= wdat;
        uim_pkg::IDX_CONTROL: ctl_q    <= wdat;
        uim_pkg::IDX_RESUME:  resume_q <= wdat;
        uim_pkg::IDX_PAUSE:   pause_q  <= wdat;
        uim_pkg::IDX_WAKE:    wake_q   <= wdat;
        default: ;
      endcase
    end
  end

  // A threshold write takes over from the mode-register level for good
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_thr_q <= uim_pkg::RST_THR;
      tx_thr_q <= uim_pkg::RST_THR;
      rx_ovr_q <= 1'b0;
      tx_ovr_q <= 1'b0;
    end else if (wr && wr_idx_q == uim_pkg::IDX_RX_THR) begin
      rx_thr_q <= wdat;
      rx_ovr_q <= 1'b1;
    end else if (wr && wr_idx_q == uim_pkg::IDX_TX_THR) begin
      tx_thr_q <= wdat;
      tx_ovr_q <= 1'b1;
    end
  end

  logic [7:0] cmask;
  assign cmask = uim_pkg::char_mask(ctl_q[uim_pkg::C_LEN +: 2]);

  // ****************************************
  // Receive queue
  // ****************************************
  uim_pkg::uim_rx_entry_t rx_mem [0:255];
  logic [7:0] rx_wp_q, rx_rp_q;
  logic [8:0] rx_cnt_q;
  logic       rx_push, rx_pop;
  uim_pkg::uim_rx_entry_t rx_head;

  assign rx_push = rx_push_valid && (rx_cnt_q != uim_pkg::DEPTH);
  assign rx_pop  = rd_acc && (idx == uim_pkg::IDX_QUEUE) && (rx_cnt_q != 9'h000);
  assign rx_head = (rx_cnt_q != 9'h000) ? rx_mem[rx_rp_q] : '0;

  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_push_entry;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_wp_q  <= 8'h00;
      rx_rp_q  <= 8'h00;
      rx_cnt_q <= 9'h000;
    end else begin
      rx_wp_q  <= rx_wp_q + {7'h00, rx_push};
      rx_rp_q  <= rx_rp_q + {7'h00, rx_pop};
      rx_cnt_q <= rx_cnt_q + {8'h00, rx_push} - {8'h00, rx_pop};
    end
  end

  // Block mode: errors of every byte since the last reset-error command
  logic [2:0] blk_err_q;
  logic       err_clr;
  assign err_clr = wr && wr_idx_q == uim_pkg::IDX_COMMAND && wdat == uim_pkg::CMD_RST_ERR;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blk_err_q <= 3'h0;
    end else if (rx_push) begin
      // Arriving errors win over a clear in the same cycle
      blk_err_q <= (err_clr ? 3'h0 : blk_err_q) |
                   {rx_push_entry.brk, rx_push_entry.fe, rx_push_entry.pe};
    end else if (err_clr) begin
      blk_err_q <= 3'h0;
    end
  end

  // ****************************************
  // Transmit queue
  // ****************************************
  logic [7:0] tx_mem [0:255];
  logic [7:0] tx_wp_q, tx_rp_q;
  logic [8:0] tx_cnt_q, tx_free;
  logic       tx_push, tx_pop, tx_valid_q;
  logic [7:0] tx_data_q;

  assign tx_free = uim_pkg::DEPTH - tx_cnt_q;
  assign tx_push = wr && wr_idx_q == uim_pkg::IDX_QUEUE && tx_cnt_q != uim_pkg::DEPTH;
  assign tx_pop  = (!tx_valid_q || tx_take) && (tx_cnt_q != 9'h000);

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_q] <= wdat;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_wp_q  <= 8'h00;
      tx_rp_q  <= 8'h00;
      tx_cnt_q <= 9'h000;
    end else begin
      tx_wp_q  <= tx_wp_q + {7'h00, tx_push};
      tx_rp_q  <= tx_rp_q + {7'h00, tx_pop};
      tx_cnt_q <= tx_cnt_q + {8'h00, tx_push} - {8'h00, tx_pop};
    end
  end

  // One-entry output stage so the transmitter sees registered data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
    end else if (tx_pop) begin
      tx_valid_q <= 1'b1;
      tx_data_q  <= tx_mem[tx_rp_q] & cmask;
    end else if (tx_take) begin
      tx_valid_q <= 1'b0;
    end
  end

  // ****************************************
  // Queue service levels
  // ****************************************
  logic [8:0] rx_lvl, tx_lvl;
  logic       rx_int, tx_int;

  // Threshold 0 stands for the 256th position
  assign rx_lvl = (rx_thr_q == 8'h00) ? uim_pkg::DEPTH : {1'b0, rx_thr_q};
  assign tx_lvl = (tx_thr_q == 8'h00) ? uim_pkg::DEPTH : {1'b0, tx_thr_q};
  assign rx_int = rx_ovr_q ? (rx_cnt_q >= rx_lvl) : (rx_cnt_q != 9'h000);
  assign tx_int = tx_ovr_q ? (tx_free >= tx_lvl) : (tx_free == uim_pkg::DEPTH);

  // ****************************************
  // Character recognition
  // ****************************************
  logic m_res, m_pau, m_wak, flow_en, addr_en;
  assign m_res   = rx_push && (rx_push_entry.data == resume_q);
  assign m_pau   = rx_push && (rx_push_entry.data == pause_q);
  assign m_wak   = rx_push && (rx_push_entry.data == wake_q);
  assign flow_en = ctl_q[uim_pkg::C_FLOW_EN];
  assign addr_en = ctl_q[uim_pkg::C_ADDR_EN];

  logic res_q, pau_q, wak_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_q <= 1'b0;
      pau_q <= 1'b0;
      wak_q <= 1'b0;
    end else begin
      res_q <= m_res && flow_en;
      pau_q <= m_pau && flow_en;
      wak_q <= m_wak && addr_en;
    end
  end

  // Flow status: upper nibble sticky until read, lower nibble live
  logic [3:0] flow_hi_q, flow_set;
  logic       flow_rd;
  assign flow_rd  = rd_acc && idx == uim_pkg::IDX_FLOW;
  assign flow_set = {m_res, m_pau, tx_pause_sent, tx_resume_sent};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flow_hi_q <= 4'h0;
    end else begin
      flow_hi_q <= (flow_rd ? 4'h0 : flow_hi_q) | flow_set;
    end
  end

  // ****************************************
  // Receiver watchdog
  // ****************************************
  logic [6:0] wd_cnt_q;
  logic       wd_evt;
  assign wd_evt = mask_q[uim_pkg::M_WDOG] && !rx_push && idle_bit_tick &&
                  (wd_cnt_q == uim_pkg::WDOG_BITS - 7'h01);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd_cnt_q <= 7'h00;
    end else if (!mask_q[uim_pkg::M_WDOG] || rx_push) begin
      wd_cnt_q <= 7'h00;
    end else if (idle_bit_tick && wd_cnt_q != uim_pkg::WDOG_BITS) begin
      wd_cnt_q <= wd_cnt_q + 7'h01;
    end
  end

  // ****************************************
  // Interrupt status and request
  // ****************************************
  logic [7:2] ev_q, ev_set;
  logic [7:0] interrupt_status;
  logic       ev_clr;

  assign ev_set = {port_change_detect,
                   wd_evt,
                   m_wak && addr_en,
                   (m_res || m_pau) && flow_en,
                   counter_zero,
                   break_change};
  assign ev_clr = wr && wr_idx_q == uim_pkg::IDX_IRQ_STAT;
  assign interrupt_status    = {ev_q, rx_int, tx_int};

  // Write one to clear; a new event in the same cycle survives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ev_q <= 6'h00;
    end else begin
      ev_q <= (ev_clr ? (ev_q & ~wdat[7:2]) : ev_q) | ev_set;
    end
  end

  logic irq_n_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|(interrupt_status & mask_q);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] status;
  logic [2:0] err_view;
  logic [31:0] rdata_d, hrdata_q;

  // Character mode shows the oldest entry, so read status first
  assign err_view = ctl_q[uim_pkg::C_BLOCK] ? blk_err_q :
                    {rx_head.brk, rx_head.fe, rx_head.pe};
  assign status = {1'b0, err_view,
                   tx_free == uim_pkg::DEPTH, tx_free != 9'h000,
                   rx_cnt_q == uim_pkg::DEPTH, rx_cnt_q != 9'h000};

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (idx)
      uim_pkg::IDX_QUEUE:    rdata_d[10:0] = {rx_head.brk, rx_head.fe, rx_head.pe,
                                              rx_head.data & cmask};
      uim_pkg::IDX_RX_FILL:  rdata_d[7:0] = rx_cnt_q[7:0];
      uim_pkg::IDX_TX_EMPTY: rdata_d[7:0] = tx_free[7:0];
      uim_pkg::IDX_STATUS:   rdata_d[7:0] = status;
      uim_pkg::IDX_IRQ_STAT: rdata_d[7:0] = interrupt_status;
      uim_pkg::IDX_MASK:     rdata_d[7:0] = mask_q;
      uim_pkg::IDX_CONTROL:  rdata_d[7:0] = ctl_q;
      uim_pkg::IDX_RESUME:   rdata_d[7:0] = resume_q;
      uim_pkg::IDX_PAUSE:    rdata_d[7:0] = pause_q;
      uim_pkg::IDX_WAKE:     rdata_d[7:0] = wake_q;
      uim_pkg::IDX_FLOW:     rdata_d[7:0] = {flow_hi_q, tx_flow_state};
      uim_pkg::IDX_RX_THR:   rdata_d[7:0] = rx_thr_q;
      uim_pkg::IDX_TX_THR:   rdata_d[7:0] = tx_thr_q;
      default:               rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (hready) begin
      hrdata_q <= rd_acc ? rdata_d : 32'h0000_0000;
    end
  end

  logic rx_space_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_space_q <= 1'b1;
    end else begin
      rx_space_q <= (rx_cnt_q + {8'h00, rx_push} - {8'h00, rx_pop}) != uim_pkg::DEPTH;
    end
  end

  // Zero-wait slave: always ready, always OKAY
  logic rdy_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdy_q <= 1'b1;
    end else begin
      rdy_q <= 1'b1;
    end
  end

  assign hreadyout               = rdy_q;
  assign hresp                   = ~rdy_q;
  assign hrdata                  = hrdata_q;
  assign rx_space                = rx_space_q;
  assign tx_valid                = tx_valid_q;
  assign tx_data                 = tx_data_q;
  assign resume_match            = res_q;
  assign pause_match             = pau_q;
  assign wake_match              = wak_q;
  assign interrupt_request_out_n = irq_n_q;

endmodule : uim_regs

//--- dv/uim_monitor.sv
/*
 * Checker for the UART host register bank, bound to uim_regs.
 * Assumes one clock, asynchronous active-low reset, word-only host bus.
 */
`timescale 1ns/10ps
module uim_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        rx_push_valid,
  input wire logic        rx_space,
  input wire logic        tx_take,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        resume_match,
  input wire logic        pause_match,
  input wire logic        wake_match,
  input wire logic        interrupt_request_out_n
);
  // ********************
  // Bus snooping
  // ********************
  logic       rd_ph_q;
  logic       wr_msk_q;
  logic [7:0] msk_q;
  wire logic  take = hsel & hready & (htrans == uim_pkg::HTRANS_NSEQ);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_ph_q  <= 1'b0;
      wr_msk_q <= 1'b0;
    end else begin
      rd_ph_q  <= take & ~hwrite;
      wr_msk_q <= take & hwrite & (haddr == 32'h0000_0094);
    end
  end

  // Mask mirror, same data-phase timing as the bank
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msk_q <= 8'h00;
    end else if (wr_msk_q) begin
      msk_q <= hwdata[7:0];
    end
  end

  // ********************
  // Properties
  // ********************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_irq_masked : assert property (
    msk_q == 8'h00 && $past(msk_q) == 8'h00 |-> interrupt_request_out_n)
    else $error("Interrupt low with all sources masked");
  a_resume_cause : assert property (
    resume_match |-> $past(rx_push_valid)) else $error("Resume match without push");
  a_pause_cause : assert property (
    pause_match |-> $past(rx_push_valid)) else $error("Pause match without push");
  a_wake_cause : assert property (
    $rose(wake_match) |-> $past(rx_push_valid)) else $error("Wake match without push");
  a_tx_hold : assert property (
    tx_valid && !tx_take |=> tx_valid && $stable(tx_data)) else $error("Tx byte not held");
  a_rd_upper : assert property (
    rd_ph_q |-> hrdata[31:11] == 21'h0) else $error("Read data upper bits set");
  a_rd_idle : assert property (
    !rd_ph_q |-> hrdata == 32'h0) else $error("Read data outside data phase");
  a_space_cause : assert property (
    $fell(rx_space) |-> $past(rx_push_valid)) else $error("Queue full without push");

  c_resume : cover property (resume_match);
  c_full : cover property (!rx_space);
  c_irq : cover property (!interrupt_request_out_n);
endmodule : uim_monitor

bind uim_regs uim_monitor u_uim_monitor (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .rx_push_valid, .rx_space, .tx_take, .tx_valid, .tx_data,
  .resume_match, .pause_match, .wake_match, .interrupt_request_out_n);

//--- dv/uim_eng.sv
/*
 * Engine-side model: receiver pushes, transmitter takes, event pulses.
 * Assumes the bank's clock; the bench calls push and ev.
 */
`timescale 1ns/10ps
module uim_eng (
  input  wire logic              clk,
  input  wire logic              stall,
  input  wire logic              tx_valid,
  input  wire logic [7:0]        tx_data,
  output logic                   rx_push_valid,
  output uim_pkg::uim_rx_entry_t rx_push_entry,
  output logic                   tx_take,
  output logic                   idle_bit_tick,
  output logic                   port_change_detect,
  output logic                   counter_zero,
  output logic                   break_change,
  output logic                   tx_resume_sent,
  output logic                   tx_pause_sent,
  output logic [3:0]             tx_flow_state
);
  // ********************
  // Stimulus and capture
  // ********************
  logic [7:0] got[$];

  initial begin
    {rx_push_valid, idle_bit_tick, port_change_detect} = 3'h0;
    {counter_zero, break_change, tx_resume_sent, tx_pause_sent} = 4'h0;
    rx_push_entry = 11'h000;
    tx_flow_state = 4'h9;
  end

  // Entry goes to its inverse once gone, so no stale byte looks valid
  task automatic push(input logic [10:0] e);
    @(posedge clk);
    rx_push_valid <= 1'b1;
    rx_push_entry <= e;
    @(posedge clk);
    rx_push_valid <= 1'b0;
    rx_push_entry <= ~e;
  endtask : push

  task automatic ev(input int i);
    @(posedge clk);
    case (i)
      7: port_change_detect <= 1'b1;
      6: idle_bit_tick <= 1'b1;
      3: counter_zero <= 1'b1;
      2: break_change <= 1'b1;
      5: tx_pause_sent <= 1'b1;
      4: tx_flow_state <= ~tx_flow_state;
      default: tx_resume_sent <= 1'b1;
    endcase
    @(posedge clk);
    {idle_bit_tick, port_change_detect, counter_zero, break_change, tx_resume_sent,
     tx_pause_sent} <= 6'h00;
  endtask : ev

  // At most every other cycle, none while stalled
  always @(posedge clk) begin
    if (tx_take && tx_valid) begin
      got.push_back(tx_data);
    end
    tx_take <= tx_valid & ~stall & ~tx_take;
  end
endmodule : uim_eng

//--- dv/testbench.sv
/*
 * Directed tests of uim_regs over its host bus.
 * Assumes the engine model uim_eng and the bound checker.
 */
`timescale 1ns/10ps
module testbench;
  logic                   clk = 1'b0;
  logic                   rstn, hsel, hwrite, stall;
  logic [1:0]             htrans;
  logic [31:0]            haddr, hwdata;
  logic [31:0]            rv;
  logic [31:0]            hrdata;
  logic [7:0]             tx_data;
  logic [3:0]             tx_flow_state;
  logic                   hreadyout, hresp, rx_space, tx_valid, tx_take, rx_push_valid;
  logic                   resume_match, pause_match, wake_match, interrupt_request_out_n;
  logic                   idle_bit_tick, port_change_detect, counter_zero, break_change;
  logic                   tx_resume_sent, tx_pause_sent;
  uim_pkg::uim_rx_entry_t rx_push_entry;
  int                     mismatches = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  int                     n_match = 0;

  always #4 clk = ~clk;

  uim_regs u_uim_regs (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .rx_push_valid, .rx_push_entry, .rx_space,
    .tx_take, .tx_valid, .tx_data, .idle_bit_tick, .port_change_detect, .counter_zero,
    .break_change, .tx_resume_sent, .tx_pause_sent, .tx_flow_state, .resume_match,
    .pause_match, .wake_match, .interrupt_request_out_n);
  uim_eng u_uim_eng (.clk, .stall, .tx_valid, .tx_data, .rx_push_valid, .rx_push_entry,
    .tx_take, .idle_bit_tick, .port_change_detect, .counter_zero, .break_change,
    .tx_resume_sent, .tx_pause_sent, .tx_flow_state);

  // ********************
  // Bus and check tasks
  // ********************
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= uim_pkg::HTRANS_NSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk

  task automatic rc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    chk(nm, exp, rv);
  endtask : rc

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  // Mask and level changes reach the pin a cycle later
  task automatic irq(input string nm, input logic exp);
    repeat (3) @(posedge clk);
    chk(nm, {31'h0, exp}, {31'h0, interrupt_request_out_n});
  endtask : irq

  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc++;
    if (resume_match || pause_match || wake_match) n_match++;
    if (cyc == 30000) begin
      mismatches++;
      results();
    end
  end

  // ********************
  // Tests
  // ********************
  initial begin
    {rstn, hsel, hwrite, stall, htrans} = 6'h00;
    {haddr, hwdata} = 64'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rc("resume", 8'h41, 32'h11);
    rc("pause", 8'h42, 32'h13);
    rc("wake", 8'h43, 32'h00);
    rc("tx empty", 8'h11, 32'h00);
    rc("status", 8'h21, 32'h0c);
    rc("unmapped", 8'h30, 32'h00);
    wr(8'h43, 32'h5a);
    rc("wake rw", 8'h43, 32'h5a);
    $display("reset test done");
    u_uim_eng.push(11'h55a);
    u_uim_eng.push(11'h2c3);
    rc("fill", 8'h10, 32'h02);
    rc("status", 8'h21, 32'h5d);
    rc("rx data", 8'h03, 32'h55a);
    rc("status", 8'h21, 32'h2d);
    rc("rx data", 8'h03, 32'h2c3);
    rc("rx empty", 8'h03, 32'h0);
    wr(8'h26, 32'h00);
    u_uim_eng.push(11'h0ff);
    rc("5-bit data", 8'h03, 32'h01f);
    wr(8'h26, 32'h07);
    u_uim_eng.push(11'h2a1);
    u_uim_eng.push(11'h4b2);
    rc("rx data", 8'h03, 32'h2a1);
    rc("rx data", 8'h03, 32'h4b2);
    rc("block err", 8'h21, 32'h7c);
    wr(8'h22, 32'h04);
    rc("err reset", 8'h21, 32'h0c);
    wr(8'h26, 32'h03);
    wr(8'h46, 32'h02);
    wr(8'h25, 32'h02);
    u_uim_eng.push(11'h001);
    irq("rx below thr", 1'b1);
    u_uim_eng.push(11'h002);
    irq("rx at thr", 1'b0);
    rc("rx data", 8'h03, 32'h001);
    irq("rx under thr", 1'b1);
    rc("rx data", 8'h03, 32'h002);
    $display("rx test done");
    wr(8'h26, 32'h1b);
    for (int i = 7; i >= 2; i--) begin
      wr(8'h24, 32'hff);
      wr(8'h25, 32'h1 << i);
      irq("irq idle", 1'b1);
      if (i == 6) begin
        repeat (63) u_uim_eng.ev(6);
        irq("63 idle bits", 1'b1);
      end
      if (i == 5 || i == 4) u_uim_eng.push(i == 5 ? 11'h05a : 11'h011);
      else u_uim_eng.ev(i);
      irq("irq source", 1'b0);
      rc("isr", 8'h24, (32'h1 << i) | 32'h1 | (i <= 4 ? 32'h2 : 32'h0));
      chk("isr bit", 32'h1, (rv >> i) & 32'h1);
      wr(8'h25, 32'h00);
      irq("irq masked", 1'b1);
    end
    wr(8'h24, 32'hff);
    wr(8'h26, 32'h03);
    wr(8'h25, 32'h30);
    u_uim_eng.push(11'h05a);
    u_uim_eng.push(11'h011);
    irq("match disabled", 1'b1);
    chk("match count", 32'h2, n_match);
    wr(8'h25, 32'h00);
    for (int i = 0; i < 4; i++) rc("drain", 8'h03, i[0] ? 32'h011 : 32'h05a);
    $display("mask test done");
    bus(8'h44, 1'b0, 32'h0);
    u_uim_eng.push(11'h013);
    u_uim_eng.ev(1);
    u_uim_eng.ev(5);
    u_uim_eng.ev(4);
    rc("flow status", 8'h44, 32'h76);
    rc("flow cleared", 8'h44, 32'h06);
    rc("rx data", 8'h03, 32'h013);
    $display("flow test done");
    stall <= 1'b1;
    wr(8'h26, 32'h02);
    wr(8'h03, 32'hff);
    wr(8'h03, 32'h80);
    wr(8'h03, 32'h3c);
    rc("tx empty", 8'h11, 32'hfe);
    wr(8'h47, 32'hfe);
    wr(8'h25, 32'h01);
    irq("tx at thr", 1'b0);
    wr(8'h47, 32'hff);
    irq("tx below thr", 1'b1);
    wr(8'h25, 32'h00);
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk("tx count", 32'h3, u_uim_eng.got.size());
    chk("tx byte0", 32'h7f, {24'h0, u_uim_eng.got[0]});
    chk("tx byte1", 32'h00, {24'h0, u_uim_eng.got[1]});
    chk("tx byte2", 32'h3c, {24'h0, u_uim_eng.got[2]});
    rc("tx empty", 8'h11, 32'h00);
    wr(8'h26, 32'h03);
    $display("tx test done");
    for (int i = 0; i < 257; i++) u_uim_eng.push({3'h0, i[7:0]});
    rc("fill full", 8'h10, 32'h00);
    chk("rx space", 32'h0, {31'h0, rx_space});
    rc("status full", 8'h21, 32'h0f);
    for (int i = 0; i < 256; i++) rc("rx seq", 8'h03, i);
    rc("rx empty", 8'h03, 32'h0);
    $display("fill test done");
    results();
  end
endmodule : testbench
